// ===== inc/ids_defs.svh
// Constants for the dynamic bandwidth switch ends
`ifndef IDS_DEFS_SVH
`define IDS_DEFS_SVH
`define IDS_TW        32
`define IDS_AW        8
`define IDS_DW        32
`define IDS_IN_DEPTH  4
`define IDS_ALT_RST   8'h00
`define IDS_TIME_RST  32'h0000_0000
`define IDS_DATA_RST  32'h0000_0000
`define IDS_TIME_INC  32'h0000_0001
`endif

// ===== inc/ids_pkg.sv
// Types for the dynamic bandwidth switch ends
package ids_pkg;
	typedef enum logic [0:0] {
		IDS_REQ_SET = 1'b0,
		IDS_REQ_DS  = 1'b1
	} ids_req_t;
	typedef enum logic [0:0] {
		IDS_D_IDLE = 1'b0,
		IDS_D_ACK  = 1'b1
	} ids_dst_t;
	typedef enum logic [1:0] {
		IDS_H_IDLE = 2'b00,
		IDS_H_WAIT = 2'b01,
		IDS_H_DONE = 2'b10
	} ids_hst_t;
endpackage

// ===== inc/ids_link_if.sv
// Link between host controller end and device end
`timescale 1ns/1ps
`default_nettype none
`include "ids_defs.svh"
interface ids_link_if;
	import ids_pkg::*;
	logic [`IDS_TW-1:0] chan_time;
	logic               req_valid;
	ids_req_t           req_kind;
	logic [`IDS_AW-1:0] req_alt;
	logic [`IDS_TW-1:0] req_time;
	logic               req_ack;
	logic               req_dyn;
	logic               out_valid;
	logic [`IDS_DW-1:0] out_data;
	logic [`IDS_TW-1:0] out_ptime;
	logic [`IDS_AW-1:0] out_fmt;
	logic               in_poll;
	logic               in_valid;
	logic [`IDS_DW-1:0] in_data;
	logic [`IDS_AW-1:0] in_fmt;
	logic               in_new_only;
	modport dev (
		input  chan_time, req_valid, req_kind, req_alt, req_time, out_valid, out_data, out_ptime, out_fmt,
		input  in_poll,
		output req_ack, req_dyn, in_valid, in_data, in_fmt, in_new_only
	);
	modport host (
		output chan_time, req_valid, req_kind, req_alt, req_time, out_valid, out_data, out_ptime, out_fmt,
		output in_poll,
		input  req_ack, req_dyn, in_valid, in_data, in_fmt, in_new_only
	);
endinterface
`default_nettype wire

// ===== core/ids_fmt_sel.sv
// Picks the data format for a presentation time against a pending switch
`timescale 1ns/1ps
`default_nettype none
module ids_fmt_sel #(
	parameter int TW = 32,
	parameter int AW = 8
) (
	input  wire logic [AW-1:0] cur_alt_i,
	input  wire logic          pend_vld_i,
	input  wire logic [TW-1:0] pend_time_i,
	input  wire logic [AW-1:0] pend_alt_i,
	input  wire logic [TW-1:0] ptime_i,
	output logic      [AW-1:0] fmt_o
);
	// At or after the switch point the new setting applies
	assign fmt_o = (pend_vld_i && (ptime_i >= pend_time_i)) ? pend_alt_i : cur_alt_i;
endmodule
`default_nettype wire

// ===== core/ids_dev.sv
// Device end: dynamic switching of an isochronous interface
`timescale 1ns/1ps
`default_nettype none
`include "ids_defs.svh"
// Notes on behaviour
// - Switchable interface reconfigures endpoints at run time
// - First step records switch point and setting
// - One switch point for whole interface
// - IN data after switch point uses new format
// - First step keeps IN buffer, old air format
// - OUT data after switch point read as new
// - OUT data before switch point read as old
// - Host completes switch naming same setting
// - After second step all traffic uses new setting
// - Unmatched selection handled as normal change
// - Starvation or overflow may raise error reporting
// - Host needs bandwidth before upward switch
// - Host never gives a past switch point
// - Host sends no old format after switch
// - Host sends no new format before switch
// - Host never polls IN holding only new data
module ids_dev
	import ids_pkg::*;
#(
	parameter int TW    = `IDS_TW,
	parameter int AW    = `IDS_AW,
	parameter int DW    = `IDS_DW,
	parameter int DEPTH = `IDS_IN_DEPTH
) (
	input  wire logic          clk_i,
	input  wire logic          rst_b_i,
	ids_link_if.dev            link,
	input  wire logic          dyn_capable_i,
	input  wire logic          prod_valid_i,
	input  wire logic [DW-1:0] prod_data_i,
	input  wire logic [TW-1:0] prod_ptime_i,
	output logic               out_valid_o,
	output logic      [DW-1:0] out_data_o,
	output logic      [AW-1:0] out_fmt_o,
	output logic               out_fmt_err_o,
	output logic      [AW-1:0] cur_alt_o,
	output logic      [AW-1:0] air_alt_o,
	output logic               pend_vld_o,
	output logic               dyn_done_o,
	output logic               in_ovf_o,
	output logic               in_empty_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	ids_dst_t           state_reg;
	logic               pend_vld_reg;
	logic [TW-1:0]      pend_time_reg;
	logic [AW-1:0]      pend_alt_reg;
	logic [AW-1:0]      cur_alt_reg;
	logic [AW-1:0]      air_alt_reg;
	logic               ack_reg;
	logic               dyn_reg;
	logic               dyn_done_reg;
	logic               flush;
	logic               take_req;

	logic [DW-1:0]      buf_data [DEPTH];
	logic [AW-1:0]      buf_fmt  [DEPTH];
	logic [PW-1:0]      wr_ptr_reg;
	logic [PW-1:0]      rd_ptr_reg;
	logic [CW-1:0]      cnt_reg;
	logic               full;
	logic               empty;
	logic               push;
	logic               pop;
	logic               ovf_reg;
	logic               empty_reg;
	logic [AW-1:0]      prod_fmt;
	logic [AW-1:0]      out_exp_fmt;

	logic               in_valid_reg;
	logic [DW-1:0]      in_data_reg;
	logic [AW-1:0]      in_fmt_reg;
	logic               new_only_reg;

	logic               out_valid_reg;
	logic [DW-1:0]      out_data_reg;
	logic [AW-1:0]      out_fmt_reg;
	logic               fmt_err_reg;

	assign take_req = (state_reg == IDS_D_IDLE) && link.req_valid;
	// A non-dynamic selection drops whatever the IN buffer holds
	assign flush    = take_req && (link.req_kind == IDS_REQ_SET)
		&& !(pend_vld_reg && (link.req_alt == pend_alt_reg));

	// Request sequencing: one answer per request
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= IDS_D_IDLE;
			ack_reg   <= 1'b0;
		end else begin
			case (state_reg)
				IDS_D_IDLE: begin
					ack_reg <= link.req_valid;
					if (link.req_valid) begin
						state_reg <= IDS_D_ACK;
					end
				end
				IDS_D_ACK: begin
					ack_reg   <= 1'b0;
					state_reg <= IDS_D_IDLE;
				end
				default: begin
					ack_reg   <= 1'b0;
					state_reg <= IDS_D_IDLE;
				end
			endcase
		end
	end

	// Pending switch record, one per interface
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend_vld_reg  <= 1'b0;
			pend_time_reg <= `IDS_TIME_RST;
			pend_alt_reg  <= `IDS_ALT_RST;
		end else if (take_req) begin
			if (link.req_kind == IDS_REQ_DS) begin
				if (dyn_capable_i) begin
					pend_vld_reg  <= 1'b1;
					pend_time_reg <= link.req_time;
					pend_alt_reg  <= link.req_alt;
				end
			end else begin
				pend_vld_reg <= 1'b0;
			end
		end
	end

	// Active setting and over-the-air setting
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cur_alt_reg  <= `IDS_ALT_RST;
			air_alt_reg  <= `IDS_ALT_RST;
			dyn_reg      <= 1'b0;
			dyn_done_reg <= 1'b0;
		end else begin
			dyn_done_reg <= 1'b0;
			if (take_req) begin
				dyn_reg <= 1'b0;
				if (link.req_kind == IDS_REQ_SET) begin
					// Air format changes on any selection, second step or normal change, never on the first step
					cur_alt_reg <= link.req_alt;
					air_alt_reg <= link.req_alt;
					if (!flush) begin
						dyn_reg      <= 1'b1;
						dyn_done_reg <= 1'b1;
					end
				end else begin
					dyn_reg <= dyn_capable_i;
				end
			end
		end
	end

	// Format of produced and received data
	ids_fmt_sel #(
		.TW (TW),
		.AW (AW)
	) u_in_fmt (
		.cur_alt_i   (cur_alt_reg),
		.pend_vld_i  (pend_vld_reg),
		.pend_time_i (pend_time_reg),
		.pend_alt_i  (pend_alt_reg),
		.ptime_i     (prod_ptime_i),
		.fmt_o       (prod_fmt)
	);

	ids_fmt_sel #(
		.TW (TW),
		.AW (AW)
	) u_out_fmt (
		.cur_alt_i   (cur_alt_reg),
		.pend_vld_i  (pend_vld_reg),
		.pend_time_i (pend_time_reg),
		.pend_alt_i  (pend_alt_reg),
		.ptime_i     (link.out_ptime),
		.fmt_o       (out_exp_fmt)
	);

	// IN buffer
	assign full  = (cnt_reg == CW'(DEPTH));
	assign empty = (cnt_reg == '0);
	assign push  = prod_valid_i && !flush;
	assign pop   = link.in_poll && !empty && !flush;

	always_ff @(posedge clk_i) begin
		if (push) begin
			buf_data[wr_ptr_reg] <= prod_data_i;
			buf_fmt[wr_ptr_reg]  <= prod_fmt;
		end
	end

	// First step never touches the buffer; only a normal change clears it
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
			empty_reg  <= 1'b1;
		end else if (flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
			empty_reg  <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_reg <= PW'((32'(wr_ptr_reg) + 1) % DEPTH);
			end
			// Overflow drops the oldest entry
			if ((push && full && !pop) || pop) begin
				rd_ptr_reg <= PW'((32'(rd_ptr_reg) + 1) % DEPTH);
			end
			// Empty flag tracks the next count, so the port comes from a flop
			if (push && !pop && !full) begin
				cnt_reg   <= cnt_reg + CW'(1);
				empty_reg <= 1'b0;
			end else if (pop && !push) begin
				cnt_reg   <= cnt_reg - CW'(1);
				empty_reg <= (cnt_reg == CW'(1));
			end
		end
	end

	// Overflow report
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ovf_reg <= 1'b0;
		end else begin
			ovf_reg <= push && full && !pop;
		end
	end

	// IN answers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			in_valid_reg <= 1'b0;
			in_data_reg  <= `IDS_DATA_RST;
			in_fmt_reg   <= `IDS_ALT_RST;
			new_only_reg <= 1'b0;
		end else begin
			in_valid_reg <= pop;
			if (pop) begin
				in_data_reg <= buf_data[rd_ptr_reg];
				in_fmt_reg  <= buf_fmt[rd_ptr_reg];
			end
			// Oldest entry new means all entries new
			new_only_reg <= !empty && (buf_fmt[rd_ptr_reg] != air_alt_reg);
		end
	end

	// OUT data interpreted by presentation time
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= `IDS_DATA_RST;
			out_fmt_reg   <= `IDS_ALT_RST;
			fmt_err_reg   <= 1'b0;
		end else begin
			out_valid_reg <= link.out_valid;
			fmt_err_reg   <= 1'b0;
			if (link.out_valid) begin
				out_data_reg <= link.out_data;
				out_fmt_reg  <= out_exp_fmt;
				fmt_err_reg  <= (link.out_fmt != out_exp_fmt);
			end
		end
	end

	assign link.req_ack     = ack_reg;
	assign link.req_dyn     = dyn_reg;
	assign link.in_valid    = in_valid_reg;
	assign link.in_data     = in_data_reg;
	assign link.in_fmt      = in_fmt_reg;
	assign link.in_new_only = new_only_reg;

	assign out_valid_o   = out_valid_reg;
	assign out_data_o    = out_data_reg;
	assign out_fmt_o     = out_fmt_reg;
	assign out_fmt_err_o = fmt_err_reg;
	assign cur_alt_o     = cur_alt_reg;
	assign air_alt_o     = air_alt_reg;
	assign pend_vld_o    = pend_vld_reg;
	assign dyn_done_o    = dyn_done_reg;
	assign in_ovf_o      = ovf_reg;
	assign in_empty_o    = empty_reg;
endmodule
`default_nettype wire

// ===== core/ids_host.sv
// Host end: issues switch requests and isochronous traffic
`timescale 1ns/1ps
`default_nettype none
`include "ids_defs.svh"
module ids_host
	import ids_pkg::*;
#(
	parameter int TW = `IDS_TW,
	parameter int AW = `IDS_AW,
	parameter int DW = `IDS_DW
) (
	input  wire logic          clk_i,
	input  wire logic          rst_b_i,
	ids_link_if.host           link,
	input  wire logic          cmd_valid_i,
	input  wire logic          cmd_ds_i,
	input  wire logic [AW-1:0] cmd_alt_i,
	input  wire logic [TW-1:0] cmd_time_i,
	input  wire logic          cmd_more_bw_i,
	input  wire logic          bw_ok_i,
	output logic               cmd_busy_o,
	output logic               cmd_done_o,
	output logic               cmd_err_o,
	output logic               cmd_dyn_o,
	input  wire logic          tx_valid_i,
	input  wire logic [DW-1:0] tx_data_i,
	input  wire logic [TW-1:0] tx_ptime_i,
	input  wire logic          poll_i,
	output logic               rx_valid_o,
	output logic      [DW-1:0] rx_data_o,
	output logic      [AW-1:0] rx_fmt_o
);
	ids_hst_t      state_reg;
	logic [TW-1:0] time_reg;
	logic          req_vld_reg;
	ids_req_t      req_kind_reg;
	logic [AW-1:0] req_alt_reg;
	logic [TW-1:0] req_time_reg;
	logic          done_reg;
	logic          err_reg;
	logic          dyn_reg;
	logic          busy_reg;
	logic          pend_vld_reg;
	logic [TW-1:0] pend_time_reg;
	logic [AW-1:0] pend_alt_reg;
	logic [AW-1:0] alt_reg;
	logic [AW-1:0] tx_fmt;
	logic          refuse;
	logic          tx_vld_reg;
	logic [DW-1:0] tx_data_reg;
	logic [TW-1:0] tx_ptime_reg;
	logic [AW-1:0] tx_fmt_reg;
	logic          poll_reg;
	logic          rx_vld_reg;
	logic [DW-1:0] rx_data_reg;
	logic [AW-1:0] rx_fmt_reg;

	// Past switch point or missing bandwidth refuses a first step
	assign refuse = cmd_ds_i && ((cmd_time_i < time_reg) || (cmd_more_bw_i && !bw_ok_i));

	// Channel time
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			time_reg <= `IDS_TIME_RST;
		end else begin
			time_reg <= time_reg + `IDS_TIME_INC;
		end
	end

	// Request sequencing
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg    <= IDS_H_IDLE;
			req_vld_reg  <= 1'b0;
			req_kind_reg <= IDS_REQ_SET;
			req_alt_reg  <= `IDS_ALT_RST;
			req_time_reg <= `IDS_TIME_RST;
			done_reg     <= 1'b0;
			err_reg      <= 1'b0;
			busy_reg     <= 1'b0;
			dyn_reg      <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			err_reg  <= 1'b0;
			case (state_reg)
				IDS_H_IDLE: begin
					if (cmd_valid_i && refuse) begin
						err_reg <= 1'b1;
					end else if (cmd_valid_i) begin
						req_vld_reg  <= 1'b1;
						req_kind_reg <= cmd_ds_i ? IDS_REQ_DS : IDS_REQ_SET;
						req_alt_reg  <= cmd_alt_i;
						req_time_reg <= cmd_time_i;
						state_reg    <= IDS_H_WAIT;
						busy_reg     <= 1'b1;
					end
				end
				IDS_H_WAIT: begin
					if (link.req_ack) begin
						req_vld_reg <= 1'b0;
						done_reg    <= 1'b1;
						dyn_reg     <= link.req_dyn;
						state_reg   <= IDS_H_DONE;
					end
				end
				IDS_H_DONE: begin
					state_reg <= IDS_H_IDLE;
					busy_reg  <= 1'b0;
				end
				default: begin
					req_vld_reg <= 1'b0;
					busy_reg    <= 1'b0;
					state_reg   <= IDS_H_IDLE;
				end
			endcase
		end
	end

	// Host copy of the pending switch
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend_vld_reg  <= 1'b0;
			pend_time_reg <= `IDS_TIME_RST;
			pend_alt_reg  <= `IDS_ALT_RST;
			alt_reg       <= `IDS_ALT_RST;
		end else if ((state_reg == IDS_H_WAIT) && link.req_ack) begin
			if (req_kind_reg == IDS_REQ_DS) begin
				pend_vld_reg  <= link.req_dyn;
				pend_time_reg <= req_time_reg;
				pend_alt_reg  <= req_alt_reg;
			end else begin
				pend_vld_reg <= 1'b0;
				alt_reg      <= req_alt_reg;
			end
		end
	end

	ids_fmt_sel #(
		.TW (TW),
		.AW (AW)
	) u_tx_fmt (
		.cur_alt_i   (alt_reg),
		.pend_vld_i  (pend_vld_reg),
		.pend_time_i (pend_time_reg),
		.pend_alt_i  (pend_alt_reg),
		.ptime_i     (tx_ptime_i),
		.fmt_o       (tx_fmt)
	);

	// OUT traffic tagged by presentation time; IN polls gated
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_vld_reg   <= 1'b0;
			tx_data_reg  <= `IDS_DATA_RST;
			tx_ptime_reg <= `IDS_TIME_RST;
			tx_fmt_reg   <= `IDS_ALT_RST;
			poll_reg     <= 1'b0;
			rx_vld_reg   <= 1'b0;
			rx_data_reg  <= `IDS_DATA_RST;
			rx_fmt_reg   <= `IDS_ALT_RST;
		end else begin
			tx_vld_reg <= tx_valid_i;
			if (tx_valid_i) begin
				tx_data_reg  <= tx_data_i;
				tx_ptime_reg <= tx_ptime_i;
				tx_fmt_reg   <= tx_fmt;
			end
			poll_reg   <= poll_i && !poll_reg && !link.in_new_only;
			rx_vld_reg <= link.in_valid;
			if (link.in_valid) begin
				rx_data_reg <= link.in_data;
				rx_fmt_reg  <= link.in_fmt;
			end
		end
	end

	assign link.chan_time = time_reg;
	assign link.req_valid = req_vld_reg;
	assign link.req_kind  = req_kind_reg;
	assign link.req_alt   = req_alt_reg;
	assign link.req_time  = req_time_reg;
	assign link.out_valid = tx_vld_reg;
	assign link.out_data  = tx_data_reg;
	assign link.out_ptime = tx_ptime_reg;
	assign link.out_fmt   = tx_fmt_reg;
	assign link.in_poll   = poll_reg;
	assign cmd_busy_o     = busy_reg;
	assign cmd_done_o     = done_reg;
	assign cmd_err_o      = err_reg;
	assign cmd_dyn_o      = dyn_reg;
	assign rx_valid_o     = rx_vld_reg;
	assign rx_data_o      = rx_data_reg;
	assign rx_fmt_o       = rx_fmt_reg;
endmodule
`default_nettype wire

// ===== tb/ids_link_properties.sv
// Concurrent checks on the link between host and device ends
`timescale 1ns/1ps
`default_nettype none
`include "ids_defs.svh"
module ids_link_properties
	import ids_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               rst_b_i,
	input  wire logic [`IDS_TW-1:0] chan_time,
	input  wire logic               req_valid,
	input  wire ids_req_t           req_kind,
	input  wire logic [`IDS_AW-1:0] req_alt,
	input  wire logic [`IDS_TW-1:0] req_time,
	input  wire logic               req_ack,
	input  wire logic               req_dyn,
	input  wire logic               out_valid,
	input  wire logic [`IDS_TW-1:0] out_ptime,
	input  wire logic [`IDS_AW-1:0] out_fmt,
	input  wire logic               in_poll,
	input  wire logic               in_valid,
	input  wire logic               in_new_only
);
	logic               pend_vld_reg;
	logic [`IDS_AW-1:0] pend_alt_reg;
	logic [`IDS_TW-1:0] pend_time_reg;
	logic [`IDS_AW-1:0] cur_alt_reg;
	logic [`IDS_AW-1:0] exp_fmt;

	// Shadow of the pending switch, updated on each answered request except a first step answered without req_dyn
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend_vld_reg  <= 1'b0;
			pend_alt_reg  <= 8'h00;
			pend_time_reg <= 32'h0000_0000;
			cur_alt_reg   <= 8'h00;
		end else if (req_ack && req_kind == IDS_REQ_DS && req_dyn) begin
			pend_vld_reg  <= 1'b1;
			pend_alt_reg  <= req_alt;
			pend_time_reg <= req_time;
		end else if (req_ack && req_kind == IDS_REQ_SET) begin
			pend_vld_reg <= 1'b0;
			cur_alt_reg  <= req_alt;
		end
	end

	assign exp_fmt = (pend_vld_reg && out_ptime >= pend_time_reg) ? pend_alt_reg : cur_alt_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_req_start;
		$rose(req_valid);
	endsequence
	sequence s_ack_release;
		req_ack ##1 (!req_ack && !req_valid);
	endsequence

	a_ack_one_cycle: assert property (s_req_start |=> req_ack)
		else $error("request not answered one cycle after it was taken");
	a_ack_release: assert property (req_ack |-> s_ack_release)
		else $error("answer not a single pulse or request not released");
	a_req_held: assert property (req_valid && !req_ack |=> req_valid && $stable(req_alt) && $stable(req_time))
		else $error("request changed before its answer");
	a_ds_not_past: assert property ($rose(req_valid) && req_kind == IDS_REQ_DS |-> req_time >= $past(chan_time))
		else $error("switch point earlier than channel time");
	a_set_pairing: assert property (req_ack && req_kind == IDS_REQ_SET |-> req_dyn == (pend_vld_reg && req_alt == pend_alt_reg))
		else $error("second step paired wrongly with pending switch");
	a_out_format: assert property (out_valid |-> out_fmt == exp_fmt)
		else $error("out word format does not match its presentation time");
	a_poll_blocked: assert property (in_poll |-> !$past(in_new_only))
		else $error("poll issued while only new format data is buffered");
	a_poll_spaced: assert property (in_poll |=> !in_poll)
		else $error("polls on consecutive cycles");
	a_in_answers: assert property (in_valid |-> $past(in_poll))
		else $error("in word without a poll");
endmodule
`default_nettype wire

// ===== tb/iso_dynamic_bandwidth_switch_tb_top.sv
// Bench joining host end and device end over the link
`timescale 1ns/1ps
`default_nettype none
`include "ids_defs.svh"
module iso_dynamic_bandwidth_switch_tb_top;
	logic               clk_i = 1'b0;
	logic               rst_b_i = 1'b0;
	logic               dyn_capable_i, prod_valid_i, cmd_valid_i, cmd_ds_i, cmd_more_bw_i, bw_ok_i, tx_valid_i, poll_i;
	logic [`IDS_DW-1:0] prod_data_i, tx_data_i, out_data_o, rx_data_o;
	logic [`IDS_TW-1:0] prod_ptime_i, cmd_time_i, tx_ptime_i, sw;
	logic [`IDS_AW-1:0] cmd_alt_i, out_fmt_o, cur_alt_o, air_alt_o, rx_fmt_o;
	logic               out_valid_o, out_fmt_err_o, pend_vld_o, dyn_done_o, in_ovf_o, in_empty_o;
	logic               cmd_busy_o, cmd_done_o, cmd_err_o, cmd_dyn_o, rx_valid_o;
	int                 n_errors = 0;
	int                 tests_run = 0;
	int                 dyn_cnt = 0;
	int                 ovf_cnt = 0;

	ids_link_if ids_link_if_inst ();

	ids_dev ids_dev_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(ids_link_if_inst), .dyn_capable_i(dyn_capable_i),
		.prod_valid_i(prod_valid_i), .prod_data_i(prod_data_i), .prod_ptime_i(prod_ptime_i),
		.out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_fmt_o(out_fmt_o), .out_fmt_err_o(out_fmt_err_o),
		.cur_alt_o(cur_alt_o), .air_alt_o(air_alt_o), .pend_vld_o(pend_vld_o), .dyn_done_o(dyn_done_o),
		.in_ovf_o(in_ovf_o), .in_empty_o(in_empty_o));

	ids_host ids_host_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(ids_link_if_inst), .cmd_valid_i(cmd_valid_i),
		.cmd_ds_i(cmd_ds_i), .cmd_alt_i(cmd_alt_i), .cmd_time_i(cmd_time_i), .cmd_more_bw_i(cmd_more_bw_i),
		.bw_ok_i(bw_ok_i), .cmd_busy_o(cmd_busy_o), .cmd_done_o(cmd_done_o), .cmd_err_o(cmd_err_o),
		.cmd_dyn_o(cmd_dyn_o), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_ptime_i(tx_ptime_i),
		.poll_i(poll_i), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_fmt_o(rx_fmt_o));

	ids_link_properties ids_link_properties_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.chan_time(ids_link_if_inst.chan_time), .req_valid(ids_link_if_inst.req_valid),
		.req_kind(ids_link_if_inst.req_kind), .req_alt(ids_link_if_inst.req_alt),
		.req_time(ids_link_if_inst.req_time), .req_ack(ids_link_if_inst.req_ack),
		.req_dyn(ids_link_if_inst.req_dyn), .out_valid(ids_link_if_inst.out_valid),
		.out_ptime(ids_link_if_inst.out_ptime), .out_fmt(ids_link_if_inst.out_fmt),
		.in_poll(ids_link_if_inst.in_poll), .in_valid(ids_link_if_inst.in_valid),
		.in_new_only(ids_link_if_inst.in_new_only));

	always #10 clk_i = ~clk_i;

	// Counts pulses that land while a task is waiting elsewhere
	always @(posedge clk_i) begin
		if (dyn_done_o === 1'b1) dyn_cnt++;
		if (in_ovf_o === 1'b1) ovf_cnt++;
	end

	task automatic end_of_test();
		if (n_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask

	task automatic run_cmd(input logic ds, input logic [7:0] alt, input logic [31:0] t, input logic bw,
		input logic exp_err);
		int i;
		cmd_ds_i = ds;
		cmd_alt_i = alt;
		cmd_time_i = t;
		cmd_more_bw_i = bw;
		cmd_valid_i = 1'b1;
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		for (i = 0; i < 10 && cmd_done_o !== 1'b1 && cmd_err_o !== 1'b1; i++) @(negedge clk_i);
		if (i == 10) begin
			chk(1'b0, "command never finished");
			end_of_test();
		end
		chk(cmd_err_o === exp_err, "command refusal differs");
		repeat (2) @(negedge clk_i);
	endtask

	task automatic send_out(input logic [31:0] p, input logic [31:0] d, input logic [7:0] f);
		int i;
		tx_ptime_i = p;
		tx_data_i = d;
		tx_valid_i = 1'b1;
		@(negedge clk_i);
		tx_valid_i = 1'b0;
		for (i = 0; i < 6 && out_valid_o !== 1'b1; i++) @(negedge clk_i);
		chk(out_valid_o === 1'b1 && out_fmt_o === f && out_data_o === d && out_fmt_err_o === 1'b0, "out word");
	endtask

	task automatic push(input logic [31:0] p, input logic [31:0] d);
		prod_ptime_i = p;
		prod_data_i = d;
		prod_valid_i = 1'b1;
		@(negedge clk_i);
		prod_valid_i = 1'b0;
		@(negedge clk_i);
	endtask

	task automatic poll(input logic exp, input logic [7:0] f, input logic [31:0] d);
		int i;
		poll_i = 1'b1;
		@(negedge clk_i);
		poll_i = 1'b0;
		for (i = 0; i < 6 && rx_valid_o !== 1'b1; i++) @(negedge clk_i);
		chk(rx_valid_o === exp, "poll answer presence");
		if (exp) chk(rx_fmt_o === f && rx_data_o === d, "poll answer word");
		@(negedge clk_i);
	endtask

	task automatic t_normal();
		run_cmd(1'b0, 8'h02, 32'h0000_0000, 1'b0, 1'b0);
		chk(cmd_dyn_o === 1'b0 && cur_alt_o === 8'h02 && air_alt_o === 8'h02 && cmd_busy_o === 1'b0, "plain selection");
	endtask

	task automatic t_switch();
		sw = ids_link_if_inst.chan_time + 32'h0000_0040;
		push(sw - 32'h0000_000A, 32'hAAAA_0001);
		run_cmd(1'b1, 8'h05, sw, 1'b0, 1'b0);
		chk(pend_vld_o === 1'b1 && cur_alt_o === 8'h02 && cmd_dyn_o === 1'b1, "first step recorded");
		push(sw + 32'h0000_0005, 32'hBBBB_0002);
		send_out(sw - 32'h0000_0001, 32'h1111_0001, 8'h02);
		send_out(sw, 32'h1111_0002, 8'h05);
		poll(1'b1, 8'h02, 32'hAAAA_0001);
		chk(ids_link_if_inst.in_new_only === 1'b1, "only new words left");
		poll(1'b0, 8'h00, 32'h0000_0000);
		run_cmd(1'b0, 8'h05, 32'h0000_0000, 1'b0, 1'b0);
		chk(cmd_dyn_o === 1'b1 && cur_alt_o === 8'h05 && air_alt_o === 8'h05, "switch completed");
		chk(pend_vld_o === 1'b0 && dyn_cnt == 1, "pending cleared once");
		poll(1'b1, 8'h05, 32'hBBBB_0002);
		send_out(sw - 32'h0000_0002, 32'h1111_0003, 8'h05);
	endtask

	task automatic t_mismatch();
		sw = ids_link_if_inst.chan_time + 32'h0000_0040;
		run_cmd(1'b1, 8'h07, sw, 1'b0, 1'b0);
		push(sw - 32'h0000_0001, 32'hCCCC_0003);
		run_cmd(1'b0, 8'h03, 32'h0000_0000, 1'b0, 1'b0);
		chk(cmd_dyn_o === 1'b0 && cur_alt_o === 8'h03 && pend_vld_o === 1'b0, "unmatched selection");
		chk(in_empty_o === 1'b1 && dyn_cnt == 1, "plain change flushes");
	endtask

	task automatic t_refuse();
		run_cmd(1'b1, 8'h09, 32'h0000_0000, 1'b0, 1'b1);
		bw_ok_i = 1'b0;
		run_cmd(1'b1, 8'h09, ids_link_if_inst.chan_time + 32'h0000_0040, 1'b1, 1'b1);
		bw_ok_i = 1'b1;
		dyn_capable_i = 1'b0;
		run_cmd(1'b1, 8'h09, ids_link_if_inst.chan_time + 32'h0000_0040, 1'b1, 1'b0);
		chk(cmd_dyn_o === 1'b0 && pend_vld_o === 1'b0, "switch refused by device");
		dyn_capable_i = 1'b1;
	endtask

	task automatic t_overflow();
		for (int k = 0; k < `IDS_IN_DEPTH + 1; k++) push(32'h0000_0100 + k, 32'hD0D0_0000 + k);
		chk(ovf_cnt == 1, "oldest word dropped when full");
		poll(1'b1, 8'h03, 32'hD0D0_0001);
	endtask

	initial begin
		dyn_capable_i = 1'b1;
		bw_ok_i = 1'b1;
		{prod_valid_i, cmd_valid_i, cmd_ds_i, cmd_more_bw_i, tx_valid_i, poll_i} = 6'h00;
		{prod_data_i, prod_ptime_i, tx_data_i, tx_ptime_i, cmd_time_i} = 160'h0;
		cmd_alt_i = 8'h00;
		repeat (6) @(negedge clk_i);
		rst_b_i = 1'b1;
		@(negedge clk_i);
		chk(cur_alt_o === 8'h00 && pend_vld_o === 1'b0 && cmd_busy_o === 1'b0, "reset state");
		t_normal();
		t_switch();
		t_mismatch();
		t_refuse();
		t_overflow();
		end_of_test();
	end
endmodule
`default_nettype wire
